/* dmx_exec.sv */
// Executes file_reg_move, file_to_file_copy and bank_literal_load.
// Assumes fetch supplies words at quarter 0 and memory read data is
// combinational from mem_raddr at quarter 1.
//
// Summary of operation
// - Destination bit 0 writes W, 1 (default) writes back to the file.
// - Access bit 0 picks the access bank, 1 uses the bank register.
// - The 8-bit operand reaches any byte of the selected 256-byte bank.
// - file_to_file_copy is two words: 1100 and source, 1111 and dest.
// - Both copy addresses span the whole 4096-byte space with no banking.
// - The working register may be the copy's source or destination.
// - The copy takes two cycles, reads first, writes in the last quarter.
// - bank_literal_load writes the bank register, flags kept.
`timescale 1ns/1ps
`include "dmx_map.svh"
module dmx_exec (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] wreg_in,
    output logic [11:0] mem_raddr,
    output logic mem_re,
    output dmx_pkg::dmx_mem_t mem_wr,
    output logic wreg_we,
    output logic [7:0] wreg_out,
    output dmx_pkg::dmx_flags_t flags,
    output logic flags_we,
    output logic [7:0] bank_pointer_register,
    output logic busy,
    output logic [1:0] quarter
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ****************************************************************
    // Quarter phases
    // ****************************************************************
    logic [1:0] q;
    dmx_quarter #(.QUARTERS(`DMX_QUARTERS)) u_quarter (
        .core_clk(core_clk),
        .rst_n(rst_sync_n),
        .quarter(q)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        dmx_pkg::dmx_state_t st;
        logic [15:0] ir;
        logic [7:0] data;
        logic [11:0] raddr;
        logic re;
        dmx_pkg::dmx_mem_t wr;
        logic wwe;
        logic [7:0] wout;
        dmx_pkg::dmx_flags_t fl;
        logic fwe;
        logic [7:0] bank;
        logic [1:0] qo;
        logic bsy;
    } dmx_regs_t;
    dmx_regs_t r;
    dmx_regs_t next_r;

    logic is_move;
    logic is_copy;
    logic is_bank;
    logic [11:0] move_addr;
    assign is_move = r.ir[15:10] == `DMX_OP_MOVE_HI;
    assign is_copy = r.ir[15:12] == `DMX_OP_COPY_HI;
    assign is_bank = r.ir[15:8] == `DMX_OP_BANK_HI;
    // Low half of access bank is RAM, high half the special registers
    always_comb begin
        if (!r.ir[`DMX_ACCESS_BIT]) begin
            move_addr = {(r.ir[7:0] >= `DMX_ACCESS_SPLIT) ?
                `DMX_ACCESS_HIGH_BANK : 4'h0, r.ir[7:0]};
        end else begin
            move_addr = {r.bank[3:0], r.ir[7:0]};
        end
    end

    always_comb begin
        next_r = r;
        next_r.re = 1'b0;
        next_r.wr.we = 1'b0;
        next_r.wwe = 1'b0;
        next_r.fwe = 1'b0;
        next_r.qo = q;
        case (r.st)
            dmx_pkg::DMX_IDLE: begin
                // A spent word is dropped so it cannot run a second time
                if (q == 2'h0) begin
                    next_r.ir = instr_valid ? instr : 16'h0000;
                end
                if (q == 2'h1) begin
                    if (is_move) begin
                        next_r.raddr = move_addr;
                        next_r.re = 1'b1;
                    end else if (is_copy) begin
                        // Source taken as is; W lives at a mapped address
                        next_r.raddr = r.ir[11:0];
                        next_r.re = 1'b1;
                    end
                end
                if (q == 2'h2 && r.re) begin
                    // W comes in on its own port, not from memory
                    if (r.raddr == `DMX_WREG_ADDR) begin
                        next_r.data = wreg_in;
                    end else begin
                        next_r.data = mem_rdata;
                    end
                end
                if (q == 2'h3) begin
                    if (is_move) begin
                        // One cycle, flags follow the moved byte
                        next_r.fl.neg = r.data[7];
                        next_r.fl.zero = r.data == 8'h00;
                        next_r.fwe = 1'b1;
                        if (r.ir[`DMX_DEST_BIT]) begin
                            next_r.wr.we = 1'b1;
                            next_r.wr.addr = move_addr;
                            next_r.wr.wdata = r.data;
                        end else begin
                            next_r.wwe = 1'b1;
                            next_r.wout = r.data;
                        end
                    end else if (is_bank) begin
                        next_r.bank = r.ir[7:0];
                    end else if (is_copy) begin
                        next_r.st = dmx_pkg::DMX_COPY_SRC;
                    end
                end
            end
            dmx_pkg::DMX_COPY_SRC: begin
                // Second word fetched; no read issued in this cycle
                if (q == 2'h0) begin
                    next_r.ir = instr_valid ? instr : 16'h0000;
                end
                if (q == 2'h3) begin
                    if (r.ir[15:12] == `DMX_OP_SECOND) begin
                        next_r.wr.we = 1'b1;
                        next_r.wr.addr = r.ir[11:0];
                        next_r.wr.wdata = r.data;
                        // Mirror to W so a copy into W lands there too
                        next_r.wwe = r.ir[11:0] == `DMX_WREG_ADDR;
                        next_r.wout = r.data;
                    end
                    next_r.st = dmx_pkg::DMX_IDLE;
                end
            end
            default: begin
                next_r.st = dmx_pkg::DMX_IDLE;
            end
        endcase
        next_r.bsy = next_r.st != dmx_pkg::DMX_IDLE;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r <= '0;
            r.st <= dmx_pkg::DMX_IDLE;
            r.bank <= `DMX_BANK_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign mem_raddr = r.raddr;
    assign mem_re = r.re;
    assign mem_wr = r.wr;
    assign wreg_we = r.wwe;
    assign wreg_out = r.wout;
    assign flags = r.fl;
    assign flags_we = r.fwe;
    assign bank_pointer_register = r.bank;
    assign busy = r.bsy;
    assign quarter = r.qo;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_flags_only_move;
        @(posedge core_clk) disable iff (!rst_sync_n)
        flags_we |-> $past(is_move);
    endproperty
    a_flags_only_move: assert property (p_flags_only_move)
        else $error("Flags written outside a register move");

    property p_zero_flag;
        @(posedge core_clk) disable iff (!rst_sync_n)
        flags_we |-> flags.zero == ($past(r.data) == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag)
        else $error("Zero flag does not match moved byte");

    property p_dest_select;
        @(posedge core_clk) disable iff (!rst_sync_n)
        flags_we |-> (mem_wr.we == $past(r.ir[`DMX_DEST_BIT])) &&
            (wreg_we != $past(r.ir[`DMX_DEST_BIT]));
    endproperty
    a_dest_select: assert property (p_dest_select)
        else $error("Move destination does not follow its bit");

    property p_bank_addr;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (mem_re && $past(is_move) && $past(r.ir[`DMX_ACCESS_BIT]))
        |-> mem_raddr[11:8] == bank_pointer_register[3:0];
    endproperty
    a_bank_addr: assert property (p_bank_addr)
        else $error("Banked read ignores the bank register");

    property p_low_byte;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (mem_re && $past(is_move)) |-> mem_raddr[7:0] == $past(r.ir[7:0]);
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("Operand byte not used as address");

    sequence s_copy_start;
        $rose(busy);
    endsequence
    sequence s_copy_end;
        ##1 busy [*3] ##1 !busy;
    endsequence
    property p_copy_len;
        @(posedge core_clk) disable iff (!rst_sync_n)
        s_copy_start |-> s_copy_end;
    endproperty
    a_copy_len: assert property (p_copy_len)
        else $error("Copy second cycle not four quarters");

    property p_no_dummy_read;
        @(posedge core_clk) disable iff (!rst_sync_n)
        busy |-> !mem_re;
    endproperty
    a_no_dummy_read: assert property (p_no_dummy_read)
        else $error("Read issued during copy second cycle");

    property p_copy_write_q3;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (mem_wr.we && !$past(is_move)) |-> quarter == 2'h3;
    endproperty
    a_copy_write_q3: assert property (p_copy_write_q3)
        else $error("Copy write outside last quarter");

    property p_copy_no_flags;
        @(posedge core_clk) disable iff (!rst_sync_n)
        busy |=> !flags_we;
    endproperty
    a_copy_no_flags: assert property (p_copy_no_flags)
        else $error("Copy touched status flags");

    property p_bank_load;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (is_bank && q == 2'h3 && !busy) |=>
            bank_pointer_register == $past(r.ir[7:0]) && !flags_we;
    endproperty
    a_bank_load: assert property (p_bank_load)
        else $error("Bank literal not loaded");
endmodule

/* dmx_map.svh */
// Constants for the data-move instruction executor: opcodes, fields, timing.
// Assumes a 16-bit instruction word and a 12-bit data address space.
`ifndef DMX_MAP_SVH
`define DMX_MAP_SVH
`define DMX_OP_MOVE_HI 6'h14
`define DMX_OP_COPY_HI 4'hC
`define DMX_OP_SECOND 4'hF
`define DMX_OP_BANK_HI 8'h01
`define DMX_DEST_BIT 9
`define DMX_ACCESS_BIT 8
`define DMX_ACCESS_SPLIT 8'h80
`define DMX_ACCESS_HIGH_BANK 4'hF
`define DMX_BANK_RESET 8'h00
`define DMX_WREG_ADDR 12'hFE8
`define DMX_CLK_HZ 10000000
`define DMX_QUARTERS 4
`endif

/* dmx_pkg.sv */
// Types shared by the data-move executor.
// Assumes dmx_map.svh is compiled alongside.
package dmx_pkg;
    typedef enum logic [1:0] {DMX_IDLE, DMX_COPY_SRC, DMX_COPY_DST} dmx_state_t;
    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } dmx_mem_t;
    typedef struct packed {
        logic neg;
        logic zero;
    } dmx_flags_t;
endpackage

/* dmx_quarter.sv */
// Quarter-cycle counter that splits each instruction cycle into four phases.
// Assumes an active-low reset from the top module, asserted at once and released in step with core_clk.
`timescale 1ns/1ps
`include "dmx_map.svh"
module dmx_quarter #(
    parameter int QUARTERS = `DMX_QUARTERS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    output logic [1:0] quarter
);
    initial begin
        if (QUARTERS != 4) begin
            $error("dmx_quarter supports exactly four quarters");
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            quarter <= 2'h0;
        end else begin
            quarter <= quarter + 2'h1;
        end
    end
endmodule

/* dmx_exec_bench.sv */
// Self-checking bench for the data-move executor.
// Assumes the design files and dmx_pkg are compiled first.
`timescale 1ns/1ps
module dmx_exec_bench;
    // ********
    // Signals
    // ********
    logic core_clk;
    logic rst_n;
    logic [15:0] instr;
    logic instr_valid;
    logic [7:0] mem_rdata;
    logic [7:0] wreg_in;
    logic [11:0] mem_raddr;
    logic mem_re;
    dmx_pkg::dmx_mem_t mem_wr;
    logic wreg_we;
    logic [7:0] wreg_out;
    dmx_pkg::dmx_flags_t flags;
    logic flags_we;
    logic [7:0] bank_pointer_register;
    logic busy;
    logic [1:0] quarter;
    int bad_count;
    int comparisons;
    int re_cnt, wr_cnt, w_cnt, f_cnt, busy_cnt;
    logic [11:0] re_addr, wr_addr;
    logic [7:0] wr_data, w_data;
    logic [1:0] f_val;
    logic [1:0] wr_q;

    dmx_exec uut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .instr(instr),
        .instr_valid(instr_valid),
        .mem_rdata(mem_rdata),
        .wreg_in(wreg_in),
        .mem_raddr(mem_raddr),
        .mem_re(mem_re),
        .mem_wr(mem_wr),
        .wreg_we(wreg_we),
        .wreg_out(wreg_out),
        .flags(flags),
        .flags_we(flags_we),
        .bank_pointer_register(bank_pointer_register),
        .busy(busy),
        .quarter(quarter)
    );

    // Data memory: content derived from the low address byte only, so reads of different banks can match
    assign mem_rdata = mem_raddr[7:0] ^ 8'h5A;

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ********
    // Monitor
    // ********
    // Sampled at the falling edge, where registered pulses have settled
    always @(negedge core_clk) begin
        if (mem_re) begin
            re_cnt++;
            re_addr = mem_raddr;
        end
        if (mem_wr.we) begin
            wr_cnt++;
            wr_addr = mem_wr.addr;
            wr_data = mem_wr.wdata;
            wr_q = quarter;
        end
        if (wreg_we) begin
            w_cnt++;
            w_data = wreg_out;
        end
        if (flags_we) begin
            f_cnt++;
            f_val = flags;
        end
        if (busy) busy_cnt++;
    end

    // ********
    // Tasks
    // ********
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic clear();
        re_cnt = 0;
        wr_cnt = 0;
        w_cnt = 0;
        f_cnt = 0;
        busy_cnt = 0;
    endtask

    // Held for four edges, so exactly one quarter 0 edge takes the word
    task automatic issue(input logic [15:0] word);
        instr <= word;
        instr_valid <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic settle();
        instr_valid <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic run_move(input logic [15:0] word, input logic [11:0] a);
        logic [7:0] d;
        d = a[7:0] ^ 8'h5A;
        clear();
        issue(word);
        settle();
        check(16'(re_cnt), 16'h0001);
        check(16'(re_addr), 16'(a));
        check(16'(wr_cnt), word[9] ? 16'h0001 : 16'h0000);
        check(16'(w_cnt), word[9] ? 16'h0000 : 16'h0001);
        if (word[9]) begin
            check(16'(wr_addr), 16'(a));
            check(16'(wr_data), 16'(d));
        end else begin
            check(16'(w_data), 16'(d));
        end
        check(16'(f_cnt), 16'h0001);
        check(16'(f_val), {14'h0000, d[7], d == 8'h00});
        check(16'(busy_cnt), 16'h0000);
    endtask

    task automatic run_copy(input logic [11:0] src, input logic [11:0] dst);
        logic [7:0] d;
        // A copy out of W takes the working register port, not memory
        d = (src == 12'hFE8) ? 8'h3C : (src[7:0] ^ 8'h5A);
        clear();
        issue({4'hC, src});
        issue({4'hF, dst});
        settle();
        check(16'(re_cnt), 16'h0001);
        check(16'(re_addr), 16'(src));
        check(16'(wr_cnt), 16'h0001);
        check(16'(wr_addr), 16'(dst));
        check(16'(wr_data), 16'(d));
        check(16'(w_cnt), (dst == 12'hFE8) ? 16'h0001 : 16'h0000);
        if (dst == 12'hFE8) begin
            check(16'(w_data), 16'(d));
        end
        check(16'(wr_q), 16'h0003);
        check(16'(f_cnt), 16'h0000);
        check(16'(busy_cnt), 16'h0004);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, errors %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ********
    // Sequence
    // ********
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        instr = 16'h0000;
        instr_valid = 1'b0;
        wreg_in = 8'h3C;
        bad_count = 0;
        comparisons = 0;
        clear();
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        check(16'(bank_pointer_register), 16'h0000);
        clear();
        issue(16'h0105);
        settle();
        check(16'(bank_pointer_register), 16'h0005);
        check(16'(f_cnt), 16'h0000);
        run_move(16'h505A, 12'h05A);
        run_move(16'h50A5, 12'hFA5);
        run_move(16'h53FF, 12'h5FF);
        run_move(16'h5100, 12'h500);
        // Destinations stay clear of the counter and stack top bytes
        run_copy(12'hFFF, 12'h000);
        run_copy(12'hFE8, 12'h123);
        run_copy(12'h456, 12'hFE8);
        // Prefix followed by a second word other than 1111 must write nothing
        clear();
        issue(16'hC010);
        issue(16'hE000);
        settle();
        check(16'(wr_cnt + w_cnt), 16'h0000);
        complete_run();
    end
endmodule
